// *** inc/t1pc_cfg.svh ***
// constants for the t1 channel payload control block
`ifndef T1PC_CFG_SVH
`define T1PC_CFG_SVH
`define NCH 8'h18
`define CH_LAST 5'h17
`define IDX_CHAN 8'h01
`define IDX_DATA_TRUNK 8'h21
`define IDX_STRK 8'h41
`define IDX_DDS_LO 8'h0a
`define IDX_DDS_HI 8'h0b
`define IDX_SNAP_CTL 8'h20
`define A_HI 31:12
`define A_SPACE 11:10
`define A_IDX 9:2
`define SUB_NONE 3'h0
`define SUB_TRUNK 3'h1
`define SUB_ALAW 3'h2
`define SUB_ULAW 3'h3
`define SUB_LOOP 3'h4
`define F_SUB 7:5
`define F_SIGN_INV 4
`define F_ODD_INV 3
`define F_EVEN_INV 2
`define F_LSB_GAP 1
`define F_GAP 0
`define F_EXTRACT 4
`define F_ABCD 3:0
`define F_AB 3:2
`define F_CD 1:0
`define F_TEST 6
`define F_SIG_TRUNK_EN 4
`define F_SNAP_TRIG 1
`define F_SNAP_AUTO 0
`define SIG_WMASK 8'h10
`define STRK_WMASK 8'h5f
`define SNAP_WMASK 8'h03
`define SIGN_MASK 8'h80
`define ODD_MASK 8'h2a
`define EVEN_MASK 8'h55
`define GAP_ALL 8'hff
`define GAP_LSB 8'h01
`define GAP_NONE 8'h00
`define ALAW_MW 64'h34212134b4a1a1b4
`define ULAW_MW 64'h1e0b0b1e9e8b8b9e
`define DDS_MAX 10'h3ff
`define DDS_LO 7:0
`define DDS_HI 9:8
`define ONE_SEC_NS 1000000000
`define CLK_PERIOD_NS 10
`endif

// *** inc/t1pc_pkg.sv ***
// types shared by the t1 channel payload control block
package t1pc_pkg;
  typedef enum logic [1:0] {
    PT_OFF = 2'b00,
    PT_8BIT = 2'b01,
    PT_7BIT = 2'b10
  } pattern_test_width_mode_e;
  typedef enum logic [1:0] {
    SP_SIG = 2'b00,
    SP_RX = 2'b01,
    SP_TX = 2'b10,
    SP_PMON = 2'b11
  } reg_space_e;
  typedef struct packed {
    logic valid;
    logic [4:0] ch;
    logic [7:0] data;
    logic [3:0] sig;
    logic [7:0] loop_data;
  } slot_in_s;
  typedef struct packed {
    logic valid;
    logic [4:0] ch;
    logic [7:0] data;
    logic [3:0] sig;
    logic sig_ins;
    logic [7:0] gap;
  } slot_out_s;
  typedef struct packed {
    logic [2:0] global_substitution_select;
    logic global_sig_trunk_enable;
    logic clock_master;
    logic per_channel_clock_enable;
  } path_cfg_s;
  typedef struct packed {
    logic valid;
    logic width7;
    logic [7:0] data;
  } prbs_det_s;
endpackage

// *** hw/t1_channel_payload_control.sv ***
// per-channel payload and signaling control for a 24-channel t1 link
//
// Notes on behaviour
// R1 - in DM format count DDS pattern errors in 10 bits; bits 9:8 readable at 0BH
// R2 - one signaling extract register per channel at 01H..18H, channels 1..24
// R3 - extract bit set and frame synced: copy channel signaling into A/B/C/D
// R4 - software keeps every extract bit zero in DM format
// R5 - A/B/C/D meaningful only while extracting; SF repeats A,B as C,D
// R6 - rx and tx spaces: control 01H, data trunk 21H, signaling trunk 41H
// R7 - per-channel substitution only while the global select is 000
// R8 - 001 trunk code, 010 A-law milliwatt, 011 mu-law milliwatt
// R9 - transmit code 100 takes payload loopback from receive elastic store
// R10 - sign inverts bit 1, odd inverts 3,5,7, even inverts 2,4,6,8
// R11 - gap bit hides whole channel clock; 56k bit hides bit 8 only
// R12 - gapping works only in clock master mode with channel clock enable
// R13 - data trunk code replaces data when substitution selects trunk
// R14 - test bit with direction 0 feeds detector, direction 1 inserts pattern
// R15 - 8-bit mode uses all bits, 7-bit mode the seven MSBs
// R16 - selected channels form one continuous stream per direction
// R17 - signaling trunk enable replaces signaling with A/B/C/D code
// R18 - signaling trunk applies by global or per-channel enable
// R19 - counter mapping registers refresh together on trigger 0 to 1
// R20 - auto snapshot bit refreshes counter mapping once per second
// R21 - reserved substitution codes leave data unchanged
// R22 - settings apply in their own channel timeslot, bit 1 first
`timescale 1ns/1ns
`include "t1pc_cfg.svh"
module t1_channel_payload_control #(
  parameter int unsigned SEC_CYCLES = `ONE_SEC_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // framer status
  input wire logic frame_sync_i,
  input wire logic sf_format_i,
  input wire logic dm_format_i,
  input wire logic dds_error_i,
  // payload paths, index 0 receive, 1 transmit
  input wire t1pc_pkg::path_cfg_s path_cfg_i [2],
  input wire t1pc_pkg::slot_in_s slot_i [2],
  output t1pc_pkg::slot_out_s slot_o [2],
  // pattern generator and detector
  input wire t1pc_pkg::pattern_test_width_mode_e pattern_test_width_mode_i,
  input wire logic pattern_test_direction_i,
  input wire logic [7:0] prbs_gen_i [2],
  output logic prbs_take_o [2],
  output t1pc_pkg::prbs_det_s prbs_det_o [2]
);
  import t1pc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] sigbuf_q [24];
  logic [7:0] ctrl_q [2][24];
  logic [7:0] data_trunk_q [2][24];
  logic [7:0] strk_q [2][24];
  logic [1:0] snap_ctl_q;
  logic snap_trig_prev_q;
  logic [9:0] dds_cnt_q;
  logic [9:0] dds_snap_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic snap_req;
  // channel hit and index for a register index inside a 24-entry range
  function automatic logic [5:0] ch_hit(input logic [7:0] idx, input logic [7:0] base);
    logic [7:0] off;
    off = idx - base;
    ch_hit = {(idx >= base) && (off < `NCH), off[4:0]};
  endfunction

  // inversion pattern from the three invert controls
  function automatic logic [7:0] inv_mask(input logic [7:0] ctl);
    inv_mask = ({8{ctl[`F_SIGN_INV]}} & `SIGN_MASK) | ({8{ctl[`F_ODD_INV]}} & `ODD_MASK)
             | ({8{ctl[`F_EVEN_INV]}} & `EVEN_MASK);
  endfunction

  // register read decode
  function automatic logic [7:0] rd_byte(input reg_space_e sp, input logic [7:0] idx);
    logic [5:0] hc;
    logic [5:0] hd;
    logic [5:0] hs;
    logic p;
    hc = ch_hit(idx, `IDX_CHAN);
    hd = ch_hit(idx, `IDX_DATA_TRUNK);
    hs = ch_hit(idx, `IDX_STRK);
    p = (sp == SP_TX);
    rd_byte = 8'h00;
    unique case (sp)
      SP_SIG: begin
        if (hc[5]) begin
          rd_byte = sigbuf_q[hc[4:0]] & (`SIG_WMASK | 8'h0f);
        end
      end
      SP_RX, SP_TX: begin
        if (hc[5]) begin
          rd_byte = ctrl_q[p][hc[4:0]];
        end else if (hd[5]) begin
          rd_byte = data_trunk_q[p][hd[4:0]];
        end else if (hs[5]) begin
          rd_byte = strk_q[p][hs[4:0]];
        end
      end
      SP_PMON: begin
        if (idx == `IDX_DDS_LO) begin
          rd_byte = dds_snap_q[`DDS_LO];
        end else if (idx == `IDX_DDS_HI) begin
          rd_byte = {6'h00, dds_snap_q[`DDS_HI]}; // R1
        end else if (idx == `IDX_SNAP_CTL) begin
          rd_byte = {6'h00, snap_ctl_q};
        end
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: address phase captured, zero-wait except read after write
  logic ap_valid_q;
  logic ap_write_q;
  reg_space_e ap_space_q;
  logic [7:0] ap_idx_q;
  logic [31:0] rdata_q;
  logic req;
  logic rd_stall;
  logic wr_en;
  logic [7:0] wbyte;
  logic [5:0] w_hc;
  logic [5:0] w_hd;
  logic [5:0] w_hs;
  logic w_path;

  // stall one cycle so a read sees the write just before it
  assign rd_stall = ap_valid_q && ap_write_q && hsel_i && htrans_i[1] && !hwrite_i;
  assign hreadyout_o = !rd_stall;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;
  assign req = hsel_i && htrans_i[1] && hready_i;
  assign wr_en = ap_valid_q && ap_write_q;
  assign wbyte = hwdata_i[7:0];
  assign w_hc = ch_hit(ap_idx_q, `IDX_CHAN);
  assign w_hd = ch_hit(ap_idx_q, `IDX_DATA_TRUNK);
  assign w_hs = ch_hit(ap_idx_q, `IDX_STRK);
  assign w_path = (ap_space_q == SP_TX);

  // address phase capture, unmapped high addresses never hit
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_space_q <= SP_SIG;
      ap_idx_q <= 8'h00;
    end else begin
      ap_valid_q <= req && (haddr_i[`A_HI] == 20'h00000);
      ap_write_q <= hwrite_i;
      ap_space_q <= reg_space_e'(haddr_i[`A_SPACE]);
      ap_idx_q <= haddr_i[`A_IDX];
    end
  end

  // read data registered at the address phase
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h00000000;
    end else if (req && !hwrite_i) begin
      rdata_q <= (haddr_i[`A_HI] == 20'h00000) ?
                 {24'h000000, rd_byte(reg_space_e'(haddr_i[`A_SPACE]), haddr_i[`A_IDX])} : 32'h00000000;
    end
  end

  // rx and tx payload control spaces
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < 2; p++) begin
        for (int c = 0; c < 24; c++) begin
          ctrl_q[p][c] <= 8'h00;
          data_trunk_q[p][c] <= 8'h00;
          strk_q[p][c] <= 8'h00;
        end
      end
    end else if (wr_en && (ap_space_q == SP_RX || ap_space_q == SP_TX)) begin
      if (w_hc[5]) begin
        ctrl_q[w_path][w_hc[4:0]] <= wbyte; // R6
      end
      if (w_hd[5]) begin
        data_trunk_q[w_path][w_hd[4:0]] <= wbyte; // R6
      end
      if (w_hs[5]) begin
        strk_q[w_path][w_hs[4:0]] <= wbyte & `STRK_WMASK; // R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive signaling extraction
  logic rx_ch_ok;
  logic ext_hit;
  logic [3:0] ext_sig;

  assign rx_ch_ok = slot_i[0].ch <= `CH_LAST;
  assign ext_hit = slot_i[0].valid && rx_ch_ok && sigbuf_q[slot_i[0].ch][`F_EXTRACT]
                 && frame_sync_i && !dm_format_i; // R3 R4
  // sf carries only a and b, so they repeat as c and d
  assign ext_sig = sf_format_i ? {slot_i[0].sig[`F_AB], slot_i[0].sig[`F_AB]} : slot_i[0].sig; // R5

  // extract enable from software, a/b/c/d from the line
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < 24; c++) begin
        sigbuf_q[c] <= 8'h00;
      end
    end else begin
      if (wr_en && ap_space_q == SP_SIG && w_hc[5]) begin
        sigbuf_q[w_hc[4:0]][`F_EXTRACT] <= wbyte[`F_EXTRACT]; // R2
      end
      if (ext_hit) begin
        sigbuf_q[slot_i[0].ch][`F_ABCD] <= ext_sig; // R3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // payload paths
  for (genvar p = 0; p < 2; p++) begin : g_path
    logic ch_ok;
    logic [7:0] ctl;
    logic [7:0] dtk;
    logic [7:0] stk;
    logic [2:0] sub;
    logic [2:0] phase_q;
    logic test_sel;
    logic [7:0] d;
    logic [7:0] gap;
    logic sig_sel;

    assign ch_ok = slot_i[p].ch <= `CH_LAST;
    assign ctl = ch_ok ? ctrl_q[p][slot_i[p].ch] : 8'h00; // R22
    assign dtk = ch_ok ? data_trunk_q[p][slot_i[p].ch] : 8'h00;
    assign stk = ch_ok ? strk_q[p][slot_i[p].ch] : 8'h00;
    assign sub = (path_cfg_i[p].global_substitution_select != `SUB_NONE) ?
                 path_cfg_i[p].global_substitution_select : ctl[`F_SUB]; // R7
    assign test_sel = slot_i[p].valid && stk[`F_TEST] && (pattern_test_width_mode_i != PT_OFF);
    assign sig_sel = path_cfg_i[p].global_sig_trunk_enable || stk[`F_SIG_TRUNK_EN]; // R17 R18
    assign prbs_take_o[p] = test_sel && pattern_test_direction_i; // R16

    // substitution, inversion, then pattern insertion
    always_comb begin
      d = slot_i[p].data;
      unique case (sub)
        `SUB_TRUNK: d = dtk; // R8 R13
        `SUB_ALAW: d = 8'(`ALAW_MW >> {~phase_q, 3'h0}); // R8
        `SUB_ULAW: d = 8'(`ULAW_MW >> {~phase_q, 3'h0}); // R8
        `SUB_LOOP: d = (p == 1) ? slot_i[p].loop_data : slot_i[p].data; // R9 R21
        default: d = slot_i[p].data; // R21
      endcase
      d = d ^ inv_mask(ctl); // R10
      if (prbs_take_o[p]) begin
        if (pattern_test_width_mode_i == PT_7BIT) begin
          d = {prbs_gen_i[p][7:1], d[0]}; // R15
        end else begin
          d = prbs_gen_i[p]; // R14 R15
        end
      end
    end

    // clock gapping only when this path masters the clock
    always_comb begin
      gap = `GAP_NONE;
      if (path_cfg_i[p].clock_master && path_cfg_i[p].per_channel_clock_enable) begin // R12
        if (ctl[`F_GAP]) begin
          gap = `GAP_ALL; // R11
        end else if (ctl[`F_LSB_GAP]) begin
          gap = `GAP_LSB; // R11
        end
      end
    end

    // milliwatt phase advances once per frame
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        phase_q <= 3'h0;
      end else if (slot_i[p].valid && slot_i[p].ch == `CH_LAST) begin
        phase_q <= phase_q + 3'h1;
      end
    end

    // output slot register
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        slot_o[p] <= '0;
      end else begin
        slot_o[p].valid <= slot_i[p].valid;
        slot_o[p].ch <= slot_i[p].ch;
        slot_o[p].data <= d;
        slot_o[p].sig <= sig_sel ? stk[`F_ABCD] : slot_i[p].sig; // R17
        slot_o[p].sig_ins <= slot_i[p].valid && sig_sel;
        slot_o[p].gap <= slot_i[p].valid ? gap : `GAP_NONE;
      end
    end

    // selected channels stream to the detector back to back
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        prbs_det_o[p] <= '0;
      end else begin
        prbs_det_o[p].valid <= test_sel && !pattern_test_direction_i; // R14 R16
        prbs_det_o[p].width7 <= pattern_test_width_mode_i == PT_7BIT; // R15
        prbs_det_o[p].data <= slot_i[p].data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dds error counter and snapshot
  assign tick = tick_cnt_q == SEC_CYCLES - 1;
  assign snap_req = (snap_ctl_q[`F_SNAP_TRIG] && !snap_trig_prev_q)
                  || (snap_ctl_q[`F_SNAP_AUTO] && tick); // R19 R20

  // snapshot control register
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      snap_ctl_q <= 2'h0;
      snap_trig_prev_q <= 1'b0;
    end else begin
      snap_trig_prev_q <= snap_ctl_q[`F_SNAP_TRIG];
      if (wr_en && ap_space_q == SP_PMON && ap_idx_q == `IDX_SNAP_CTL) begin
        snap_ctl_q <= 2'(wbyte & `SNAP_WMASK);
      end
    end
  end

  // one second tick
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || tick) begin
      tick_cnt_q <= 32'h00000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001; // R20
    end
  end

  // counting saturates; a snapshot restarts the count and keeps a same-cycle error
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      dds_cnt_q <= 10'h000;
      dds_snap_q <= 10'h000;
    end else if (snap_req) begin
      dds_snap_q <= dds_cnt_q; // R19
      dds_cnt_q <= {9'h000, dds_error_i && dm_format_i};
    end else if (dds_error_i && dm_format_i && dds_cnt_q != `DDS_MAX) begin
      dds_cnt_q <= dds_cnt_q + 10'h001; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [4:0] rx_ch;
  logic gap_ok0;
  logic tx_loop_plain;
  logic [7:0] tx_loop_data;

  assign rx_ch = slot_i[0].ch;
  assign gap_ok0 = path_cfg_i[0].clock_master && path_cfg_i[0].per_channel_clock_enable;
  assign tx_loop_plain = slot_i[1].valid && g_path[1].sub == `SUB_LOOP
                       && inv_mask(g_path[1].ctl) == 8'h00 && !prbs_take_o[1];
  assign tx_loop_data = slot_i[1].loop_data;

  chk_snap_copy: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R19
    snap_req |=> dds_snap_q == $past(dds_cnt_q)) else $error("snapshot did not copy count");
  chk_auto_tick: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R20
    (tick && snap_ctl_q[`F_SNAP_AUTO]) |=> dds_snap_q == $past(dds_cnt_q)) else $error("auto snapshot missed tick");
  chk_dds_increment: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
    (dds_error_i && dm_format_i && !snap_req && dds_cnt_q != `DDS_MAX) |=> dds_cnt_q == $past(dds_cnt_q) + 10'h001)
    else $error("dds count did not step");
  chk_extract_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R3
    (slot_i[0].valid && rx_ch_ok && !(frame_sync_i && sigbuf_q[rx_ch][`F_EXTRACT]))
    |=> sigbuf_q[$past(rx_ch)][`F_ABCD] == $past(sigbuf_q[rx_ch][`F_ABCD])) else $error("extract without enable");
  chk_sf_repeat: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
    (ext_hit && sf_format_i) |=> sigbuf_q[$past(rx_ch)][`F_CD] == sigbuf_q[$past(rx_ch)][`F_AB])
    else $error("sf c/d not repeating a/b");
  chk_gap_master: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
    (slot_o[0].gap != `GAP_NONE) |-> $past(gap_ok0)) else $error("rx gap outside master mode");
  chk_loop_data: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
    tx_loop_plain |=> slot_o[1].data == $past(tx_loop_data)) else $error("tx loopback data wrong");
  chk_det_route: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R14
    prbs_det_o[0].valid |-> !$past(pattern_test_direction_i)) else $error("detector fed in insert direction");
  chk_bus_stall: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !hreadyout_o |=> hreadyout_o) else $error("bus stalled more than one cycle");
endmodule

// *** tb/t1_line_partner.sv ***
// line framer and backplane model feeding both payload paths
`timescale 1ns/1ns
module t1_line_partner (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // generator handshake
  input wire logic prbs_take_i [2],
  // channel streams
  output t1pc_pkg::slot_in_s slot_o [2],
  output logic [7:0] prbs_gen_o [2]
);
  import t1pc_pkg::*;
  logic [4:0] ch_q;
  logic [2:0] frame_q;
  ////////////////////////////////////////
  // 24 channel slots, then one framing gap cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || ch_q == 5'h18) begin
      ch_q <= 5'h00;
    end else begin
      ch_q <= ch_q + 5'h01;
    end
  end
  // frame count steps at each gap
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      frame_q <= 3'h0;
    end else if (ch_q == 5'h18) begin
      frame_q <= frame_q + 3'h1;
    end
  end
  ////////////////////////////////////////
  for (genvar p = 0; p < 2; p++) begin : g_path
    logic [7:0] d;
    logic [7:0] gen_q;
    // data moves every cycle, also in the gap, so no stale byte lingers
    assign d = {frame_q, ch_q} + 8'(p * 71);
    assign slot_o[p] = '{ch_q < 5'h18, ch_q, d, ch_q[3:0] ^ 4'h9, {d[3:0], d[7:4]}};
    assign prbs_gen_o[p] = gen_q;
    // stand-in generator, one step per byte taken
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        gen_q <= 8'h01;
      end else if (prbs_take_i[p]) begin
        gen_q <= gen_q + 8'h3b;
      end
    end
  end
endmodule

// *** tb/t1_channel_payload_control_bench.sv ***
// self-checking bench for the t1 channel payload control block
`timescale 1ns/1ns
`include "t1pc_cfg.svh"
module t1_channel_payload_control_bench;
  import t1pc_pkg::*;
  logic clock_i, rst_b_i, hsel, hwrite, hready, hresp, fsync, sf, dm, dds, dir, stake;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  path_cfg_s cfg [2];
  slot_in_s slot_i [2], in_q [2], sent;
  slot_out_s slot_o [2], got;
  pattern_test_width_mode_e mode;
  logic [7:0] gen [2], gen_q [2], sgen;
  logic take [2], take_q [2];
  prbs_det_s det [2], sdet;
  logic [2:0] ph [2], ph_q [2], sph;
  int err_total = 0, check_count = 0, cyc = 0;
  t1_channel_payload_control #(.SEC_CYCLES(50)) t1_channel_payload_control_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .frame_sync_i(fsync), .sf_format_i(sf), .dm_format_i(dm),
    .dds_error_i(dds), .path_cfg_i(cfg), .slot_i(slot_i), .slot_o(slot_o), .pattern_test_width_mode_i(mode),
    .pattern_test_direction_i(dir), .prbs_gen_i(gen), .prbs_take_o(take), .prbs_det_o(det));
  t1_line_partner t1_line_partner_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .prbs_take_i(take),
    .slot_o(slot_i), .prbs_gen_o(gen));
  ////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end
  // inputs one cycle behind the outputs, milliwatt phase per path
  always @(posedge clock_i) begin
    for (int p = 0; p < 2; p++) begin
      in_q[p] <= slot_i[p];
      gen_q[p] <= gen[p];
      take_q[p] <= take[p];
      ph_q[p] <= ph[p];
      ph[p] <= !rst_b_i ? 3'h0 : ph[p] + 3'(slot_i[p].valid && slot_i[p].ch == 5'h17);
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // one ahb-lite single word transfer, entered at a rising edge
  task automatic bus(input logic wr, input logic [1:0] sp, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, sp, idx, 2'b00};
    do @(posedge clock_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clock_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [1:0] sp, input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, sp, idx, v);
  endtask
  task automatic rdchk(input logic [1:0] sp, input logic [7:0] idx, input logic [7:0] want);
    bus(1'b0, sp, idx, 8'h00);
    check(rd, {24'h0, want});
  endtask
  // wait for a channel's output slot, keep what went in for it
  task automatic grab(input int p, input logic [4:0] ch);
    @(posedge clock_i);
    do @(posedge clock_i); while (!(slot_o[p].valid === 1'b1 && slot_o[p].ch === ch));
    got = slot_o[p];
    sent = in_q[p];
    sgen = gen_q[p];
    stake = take_q[p];
    sph = ph_q[p];
    sdet = det[p];
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rdchk(2'h1, 8'h01, 8'h00);
    check(hresp, 1'b0);
    wr(2'h2, 8'h38, 8'ha5);
    rdchk(2'h2, 8'h38, 8'ha5);
    wr(2'h0, 8'h18, 8'hff);
    rdchk(2'h0, 8'h18, 8'h10);
    wr(2'h1, 8'h19, 8'h77);
    rdchk(2'h1, 8'h19, 8'h00);
    wr(2'h0, 8'h18, 8'h00);
  endtask
  task automatic t_channel_substitution_select();
    logic [7:0] w;
    for (int p = 0; p < 2; p++) begin
      wr(2'(p + 1), 8'h26, 8'hc3);
      for (int c = 0; c < 8; c++) begin
        wr(2'(p + 1), 8'h06, 8'(c << 5));
        grab(p, 5'h05);
        case (c)
          1: w = 8'hc3;
          2: w = 8'(`ALAW_MW >> (8 * (7 - sph)));
          3: w = 8'(`ULAW_MW >> (8 * (7 - sph)));
          4: w = p ? sent.loop_data : sent.data;
          default: w = sent.data;
        endcase
        check(got.data, w);
      end
      wr(2'(p + 1), 8'h06, 8'h40);
      cfg[p].global_substitution_select <= 3'h1;
      grab(p, 5'h05);
      check(got.data, 8'hc3);
      cfg[p].global_substitution_select <= 3'h0;
      wr(2'(p + 1), 8'h06, 8'h00);
    end
  endtask
  task automatic t_inv();
    for (int k = 0; k < 8; k++) begin
      wr(2'h1, 8'h0a, 8'(k << 2));
      grab(0, 5'h09);
      check(got.data, sent.data ^ (k[2] ? 8'h80 : 8'h00) ^ (k[1] ? 8'h2a : 8'h00) ^ (k[0] ? 8'h55 : 8'h00));
    end
    wr(2'h1, 8'h0a, 8'h3c);
    grab(0, 5'h09);
    check(got.data, 8'hff);
    wr(2'h1, 8'h0a, 8'h00);
  endtask
  task automatic t_gap();
    for (int p = 0; p < 2; p++) begin
      for (int g = 1; g < 4; g++) begin
        wr(2'(p + 1), 8'h0c, 8'(g));
        grab(p, 5'h0b);
        check(got.gap, g == 2 ? 8'h01 : 8'hff);
      end
      grab(p, 5'h0a);
      check(got.gap, 8'h00);
      cfg[p].per_channel_clock_enable <= 1'b0;
      grab(p, 5'h0b);
      check(got.gap, 8'h00);
      cfg[p].per_channel_clock_enable <= 1'b1;
      cfg[p].clock_master <= 1'b0;
      grab(p, 5'h0b);
      check(got.gap, 8'h00);
      cfg[p].clock_master <= 1'b1;
      wr(2'(p + 1), 8'h0c, 8'h00);
    end
  endtask
  task automatic t_extract();
    wr(2'h0, 8'h05, 8'h10);
    grab(0, 5'h04);
    rdchk(2'h0, 8'h05, 8'h10);
    fsync <= 1'b1;
    grab(0, 5'h04);
    rdchk(2'h0, 8'h05, 8'h1d);
    rdchk(2'h0, 8'h06, 8'h00);
    sf <= 1'b1;
    grab(0, 5'h04);
    rdchk(2'h0, 8'h05, 8'h1f);
    fsync <= 1'b0;
    sf <= 1'b0;
    wr(2'h0, 8'h05, 8'h00);
  endtask
  task automatic t_strk();
    wr(2'h1, 8'h47, 8'h16);
    grab(0, 5'h06);
    check({got.sig_ins, got.sig}, 5'h16);
    grab(0, 5'h07);
    check({got.sig_ins, got.sig}, {1'b0, sent.sig});
    wr(2'h1, 8'h47, 8'h06);
    cfg[0].global_sig_trunk_enable <= 1'b1;
    grab(0, 5'h06);
    check({got.sig_ins, got.sig}, 5'h16);
    cfg[0].global_sig_trunk_enable <= 1'b0;
    wr(2'h1, 8'h47, 8'h00);
  endtask
  task automatic t_prbs();
    logic [7:0] w;
    wr(2'h2, 8'h43, 8'h40);
    wr(2'h2, 8'h45, 8'h40);
    mode <= PT_8BIT;
    dir <= 1'b1;
    grab(1, 5'h02);
    check({stake, got.data}, {1'b1, sgen});
    w = sgen;
    grab(1, 5'h04);
    check({stake, got.data}, {1'b1, w + 8'h3b});
    grab(1, 5'h03);
    check({stake, got.data}, {1'b0, sent.data});
    mode <= PT_7BIT;
    grab(1, 5'h02);
    check(got.data, {sgen[7:1], sent.data[0]});
    dir <= 1'b0;
    wr(2'h1, 8'h43, 8'h40);
    grab(0, 5'h02);
    check({sdet.valid, sdet.width7, sdet.data, got.data}, {2'b11, sent.data, sent.data});
    mode <= PT_8BIT;
    grab(0, 5'h02);
    check({stake, sdet.valid, sdet.width7}, 3'b010);
    grab(0, 5'h03);
    check(sdet.valid, 1'b0);
    mode <= PT_OFF;
    wr(2'h1, 8'h43, 8'h00);
    wr(2'h2, 8'h43, 8'h00);
    wr(2'h2, 8'h45, 8'h00);
  endtask
  task automatic t_dds();
    dds <= 1'b1;
    repeat (10) @(posedge clock_i);
    dm <= 1'b1;
    repeat (300) @(posedge clock_i);
    dds <= 1'b0;
    wr(2'h3, 8'h20, 8'h02);
    wr(2'h3, 8'h20, 8'h00);
    rdchk(2'h3, 8'h0a, 8'h2c);
    rdchk(2'h3, 8'h0b, 8'h01);
    dds <= 1'b1;
    wr(2'h3, 8'h20, 8'h01);
    repeat (150) @(posedge clock_i);
    rdchk(2'h3, 8'h0a, 8'h32);
    dds <= 1'b0;
    wr(2'h3, 8'h20, 8'h00);
    dm <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    {hsel, hwrite, fsync, sf, dm, dds, dir} = 7'h00;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    mode = PT_OFF;
    cfg[0] = '{3'h0, 1'b0, 1'b1, 1'b1};
    cfg[1] = '{3'h0, 1'b0, 1'b1, 1'b1};
    rst_b_i = 1'b0;
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_channel_substitution_select();
    t_inv();
    t_gap();
    t_extract();
    t_strk();
    t_prbs();
    t_dds();
    print_verdict();
  end
endmodule
